// ===== core/scp_pkg.sv
package scp_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_CTRL_A = 3'h0;
  localparam logic [2:0] ADDR_CTRL_B = 3'h1;
  localparam logic [2:0] ADDR_IRQ_EN = 3'h2;
  localparam logic [2:0] ADDR_FLAGS = 3'h3;
  localparam logic [2:0] ADDR_DATA = 3'h4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CA_ORDER = 6;
  localparam int CA_ENABLE = 0;
  localparam int CB_BUF = 7;
  localparam int CB_WFR = 6;
  localparam int CB_MODE_LO = 0;
  localparam int IE_RXC = 7;
  localparam int IE_TXC = 6;
  localparam int IE_DRE = 5;
  localparam int IE_SS = 4;
  localparam int IE_BASIC = 0;
  localparam int FN_IF = 7;
  localparam int FN_WRITE_COLLISION_FLAG = 6;
  localparam int FB_RXC = 7;
  localparam int FB_TXC = 6;
  localparam int FB_DRE = 5;
  localparam int FB_SS = 4;
  localparam int FB_OVF = 0;
  // Mode field: bit 1 idle-high clock, bit 0 setup on leading edge
  localparam int MODE_IDLE_HIGH = 1;
  localparam int MODE_SETUP_LEAD = 0;

  // ----------------------------------------------------------------
  // Writable masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_A_MASK = 8'h77;
  localparam logic [7:0] CTRL_B_MASK = 8'hC7;
  localparam logic [7:0] IRQ_EN_MASK = 8'hF1;
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] IRQ_EN_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] RX_DEPTH = 2'h2;

  typedef enum logic [0:0] {ST_IDLE, ST_SHIFT} scp_state_t;

  // Shift one bit into a byte in the chosen bit order
  function automatic logic [7:0] scp_shift(input logic [7:0] sr, input logic b,
                                           input logic lsb_first);
    scp_shift = lsb_first ? {b, sr[7:1]} : {sr[6:0], b};
  endfunction : scp_shift

endpackage : scp_pkg

// ===== core/scp_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// Two-flop synchroniser for pin inputs
// ------------------------------------------------------------------
module scp_sync
  import scp_pkg::*;
#(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second; reset value idle-high suits select
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '1;
      sync_out <= '1;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : scp_sync
`default_nettype wire

// ===== core/scp_port.sv
// Operation
// - Wait-for-receive: first byte loads shift register next cycle
// - Write to full transmit buffer is discarded
// - Byte done: pending buffer copied to shift register
// - Flag timing same for both wait settings
// - Empty flag drops on write, rises on reload
// - Receive flag after empty, transfer-complete one later
// - Select, MOSI, SCK always inputs in client mode
// - Selected: shift out on MISO if direction output
// - Deselected: ignore data, MISO released
// - Select high resets engine, aborts transfer
// - Four modes, launch and capture opposite edges
// - Mode encodes idle level and sample edge
// - Leading edge first, trailing edge last
// - Serial clock level event, two-cycle minimum; the event follows the synchronised SCK, with no stretching to two cycles
// - No incoming events consumed
// - Interrupt sources differ normal versus buffered
// - Flags set regardless of enable
// - Each buffered source has own enable bit; normal sources share one
// - Request held while flag set and enabled
// - Bit order: 0 MSB first, 1 LSB first
`timescale 1ns/1ps
`default_nettype none
module scp_port
  import scp_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [2:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic SCK,
  input wire logic SS_N,
  input wire logic MOSI,
  input wire logic MISO_DIR_OUT,
  output logic MISO_O,
  output logic MISO_OE,
  output logic IRQ,
  output logic SCK_EVENT
);
  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [2:0] pins_s;
  logic sck_s, ss_n_s, mosi_s;

  // Pins are only ever sampled, never driven
  scp_sync #(.W(3)) u_sync (
    .clk(REF_CLK),
    .rst(RST),
    .async_in({SCK, SS_N, MOSI}),
    .sync_out(pins_s)
  );
  assign sck_s = pins_s[2];
  assign ss_n_s = pins_s[1];
  assign mosi_s = pins_s[0];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] ctrl_a_q, ctrl_b_q, irq_en_q;
  logic [7:0] tx_sr_q, rx_sr_q, tx_buf_q, rx0_q, rx1_q;
  logic [1:0] rx_cnt_q;
  logic [2:0] bit_cnt_q;
  logic armed_q, sck_prev_q, ss_prev_q, sr_loaded_q;
  logic dre_q, rxc_q, txc_q, select_trigger_flag_q, ovf_q, if_q, write_collision_flag_q, clr_armed_q;
  logic done_p1_q, done_p2_q, last_p1_q, last_p2_q;
  scp_state_t state_q, state_d;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic enable, buffered, wfr, lsb_first, cpol, cpha;
  logic sck_edge, lead_edge, sample_edge, setup_edge, selected, done, busy;
  logic wr_a, wr_b, wr_ie, wr_fl, wr_data, rd_fl, rd_data;
  logic pop, push, tx_direct, clr_normal;
  logic [7:0] rx_byte_d;

  assign enable = ctrl_a_q[CA_ENABLE];
  assign lsb_first = ctrl_a_q[CA_ORDER];
  assign buffered = ctrl_b_q[CB_BUF];
  assign wfr = ctrl_b_q[CB_WFR];
  assign cpol = ctrl_b_q[CB_MODE_LO + MODE_IDLE_HIGH];
  assign cpha = ctrl_b_q[CB_MODE_LO + MODE_SETUP_LEAD];
  // Leading edge leaves the idle level, trailing edge returns to it
  assign sck_edge = sck_s != sck_prev_q;
  assign lead_edge = sck_edge && (sck_s != cpol);
  // Capture and launch always sit on opposite edges
  assign sample_edge = sck_edge && (lead_edge ^ cpha);
  assign setup_edge = sck_edge && !(lead_edge ^ cpha);
  assign selected = enable && !ss_n_s && (state_q == ST_SHIFT);
  assign done = selected && sample_edge && (bit_cnt_q == LAST_BIT);
  assign busy = selected && ((bit_cnt_q != 3'h0) || armed_q);
  assign rx_byte_d = scp_shift(rx_sr_q, mosi_s, lsb_first);

  assign wr_a = REG_WR && (REG_ADDR == ADDR_CTRL_A);
  assign wr_b = REG_WR && (REG_ADDR == ADDR_CTRL_B);
  assign wr_ie = REG_WR && (REG_ADDR == ADDR_IRQ_EN);
  assign wr_fl = REG_WR && (REG_ADDR == ADDR_FLAGS);
  assign wr_data = REG_WR && (REG_ADDR == ADDR_DATA);
  assign rd_fl = REG_RD && (REG_ADDR == ADDR_FLAGS);
  assign rd_data = REG_RD && (REG_ADDR == ADDR_DATA);
  assign pop = rd_data && buffered && (rx_cnt_q != 2'h0);
  assign push = done;
  // First write with select high bypasses the buffer in wait mode
  assign tx_direct = buffered && wfr && ss_n_s && !sr_loaded_q && !dre_q;
  // Normal flags clear on a data access after flags were read while set
  assign clr_normal = (wr_data || rd_data) && clr_armed_q;

  // ----------------------------------------------------------------
  // Engine state machine
  // ----------------------------------------------------------------
  // Deselect drops straight to idle, whatever the bit position
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (enable && !ss_n_s) begin
          state_d = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (ss_n_s || !enable) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Bit counter and receive shifter; deselect discards partial bits
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 3'h0;
      rx_sr_q <= DATA_RST;
      armed_q <= 1'b0;
      // Matches the synchroniser's reset level, so no false edge follows reset
      sck_prev_q <= 1'b1;
      ss_prev_q <= 1'b1;
    end else begin
      state_q <= state_d;
      sck_prev_q <= sck_s;
      ss_prev_q <= ss_n_s;
      if (!selected) begin
        bit_cnt_q <= 3'h0;
        armed_q <= 1'b0;
      end else if (sample_edge) begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
        rx_sr_q <= rx_byte_d;
        armed_q <= !done;
      end else if (setup_edge) begin
        armed_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  // Shift register: direct write, reload at byte end, or shift out
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      tx_sr_q <= DATA_RST;
      tx_buf_q <= DATA_RST;
      dre_q <= 1'b1;
      sr_loaded_q <= 1'b0;
    end else begin
      if (done && buffered) begin
        if (!dre_q) begin
          tx_sr_q <= tx_buf_q;
          dre_q <= 1'b1;
          sr_loaded_q <= 1'b1;
        end else begin
          sr_loaded_q <= 1'b0;
        end
      end else if (tx_direct) begin
        tx_sr_q <= tx_buf_q;
        dre_q <= 1'b1;
        sr_loaded_q <= 1'b1;
      end else if (wr_data && !buffered && !busy) begin
        tx_sr_q <= REG_WDATA;
      end else if (selected && setup_edge && armed_q) begin
        tx_sr_q <= scp_shift(tx_sr_q, 1'b0, lsb_first);
      end
      if (wr_data && buffered && dre_q) begin
        tx_buf_q <= REG_WDATA;
        dre_q <= 1'b0;
      end
      if (!buffered) begin
        sr_loaded_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive stages
  // ----------------------------------------------------------------
  // Two stages in buffered mode, one overwritten stage in normal mode
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rx0_q <= DATA_RST;
      rx1_q <= DATA_RST;
      rx_cnt_q <= 2'h0;
    end else if (!buffered) begin
      rx_cnt_q <= 2'h0;
      if (push) begin
        rx0_q <= rx_byte_d;
      end
    end else if (push && pop) begin
      rx0_q <= (rx_cnt_q == 2'h2) ? rx1_q : rx_byte_d;
      rx1_q <= rx_byte_d;
    end else if (pop) begin
      rx0_q <= rx1_q;
      rx_cnt_q <= rx_cnt_q - 2'h1;
    end else if (push && rx_cnt_q != RX_DEPTH) begin
      if (rx_cnt_q == 2'h0) begin
        rx0_q <= rx_byte_d;
      end else begin
        rx1_q <= rx_byte_d;
      end
      rx_cnt_q <= rx_cnt_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  // Byte-end pipeline spaces empty, receive and complete one apart
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      done_p1_q <= 1'b0;
      done_p2_q <= 1'b0;
      last_p1_q <= 1'b0;
      last_p2_q <= 1'b0;
    end else begin
      done_p1_q <= done && buffered;
      done_p2_q <= done_p1_q;
      last_p1_q <= done && buffered && dre_q;
      last_p2_q <= last_p1_q;
    end
  end

  // Set wins over clear; flags set whatever the enables say
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rxc_q <= 1'b0;
      txc_q <= 1'b0;
      select_trigger_flag_q <= 1'b0;
      ovf_q <= 1'b0;
      if_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      clr_armed_q <= 1'b0;
    end else begin
      if (done_p1_q) begin
        rxc_q <= 1'b1;
      end else if ((wr_fl && REG_WDATA[FB_RXC]) || (pop && rx_cnt_q == 2'h1)) begin
        rxc_q <= 1'b0;
      end
      if (done_p2_q && last_p2_q) begin
        txc_q <= 1'b1;
      end else if (wr_fl && REG_WDATA[FB_TXC]) begin
        txc_q <= 1'b0;
      end
      if (buffered && !ss_n_s && ss_prev_q) begin
        select_trigger_flag_q <= 1'b1;
      end else if (wr_fl && REG_WDATA[FB_SS]) begin
        select_trigger_flag_q <= 1'b0;
      end
      if (push && buffered && rx_cnt_q == RX_DEPTH && !pop) begin
        ovf_q <= 1'b1;
      end else if (wr_fl && REG_WDATA[FB_OVF]) begin
        ovf_q <= 1'b0;
      end
      if (done && !buffered) begin
        if_q <= 1'b1;
      end else if (clr_normal) begin
        if_q <= 1'b0;
      end
      if (wr_data && !buffered && busy) begin
        write_collision_flag_q <= 1'b1;
      end else if (clr_normal) begin
        write_collision_flag_q <= 1'b0;
      end
      if (rd_fl && (if_q || write_collision_flag_q)) begin
        clr_armed_q <= 1'b1;
      end else if (clr_normal) begin
        clr_armed_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register bus and outputs
  // ----------------------------------------------------------------
  logic [7:0] flags_view, rd_mux;
  logic irq_d;

  assign flags_view = buffered ?
    {rxc_q, txc_q, dre_q, select_trigger_flag_q, 3'h0, ovf_q} : {if_q, write_collision_flag_q, 6'h00};
  assign rd_mux = (REG_ADDR == ADDR_CTRL_A) ? ctrl_a_q :
                  (REG_ADDR == ADDR_CTRL_B) ? ctrl_b_q :
                  (REG_ADDR == ADDR_IRQ_EN) ? irq_en_q :
                  (REG_ADDR == ADDR_FLAGS) ? flags_view :
                  (REG_ADDR == ADDR_DATA) ? rx0_q : 8'h00;
  // One vector; sources chosen by mode, buffered ones each gated by its own enable, normal ones by one shared enable
  assign irq_d = buffered ?
    ((rxc_q && irq_en_q[IE_RXC]) || (txc_q && irq_en_q[IE_TXC]) ||
     (dre_q && irq_en_q[IE_DRE]) || (select_trigger_flag_q && irq_en_q[IE_SS])) :
    ((if_q || write_collision_flag_q) && irq_en_q[IE_BASIC]);

  // Control registers and registered read data, zero outside a read
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ctrl_a_q <= CTRL_A_RST;
      ctrl_b_q <= CTRL_B_RST;
      irq_en_q <= IRQ_EN_RST;
      REG_RDATA <= 8'h00;
    end else begin
      if (wr_a) begin
        ctrl_a_q <= REG_WDATA & CTRL_A_MASK;
      end
      if (wr_b) begin
        ctrl_b_q <= REG_WDATA & CTRL_B_MASK;
      end
      if (wr_ie) begin
        irq_en_q <= REG_WDATA & IRQ_EN_MASK;
      end
      REG_RDATA <= REG_RD ? rd_mux : 8'h00;
    end
  end

  // Pin and request outputs all from flops; event is the only outbound
  // event, nothing is consumed from an event system
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      MISO_O <= 1'b0;
      MISO_OE <= 1'b0;
      IRQ <= 1'b0;
      SCK_EVENT <= 1'b0;
    end else begin
      MISO_OE <= selected && MISO_DIR_OUT;
      MISO_O <= lsb_first ? tx_sr_q[0] : tx_sr_q[7];
      IRQ <= irq_d;
      // Follows the synchronised clock, so each level lasts as long as the synchronised SCK level
      SCK_EVENT <= sck_s;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_empty_drop: assert property (@(posedge REF_CLK) disable iff (RST)
    wr_data && buffered && dre_q && !done |=> !dre_q)
    else $error("empty flag did not drop on buffer write");
  chk_full_discard: assert property (@(posedge REF_CLK) disable iff (RST)
    wr_data && buffered && !dre_q |=> $stable(tx_buf_q))
    else $error("write to full buffer changed it");
  chk_first_direct: assert property (@(posedge REF_CLK) disable iff (RST)
    tx_direct && !(done && buffered) |=> tx_sr_q == $past(tx_buf_q) && dre_q)
    else $error("first byte not moved to shift register");
  chk_reload_done: assert property (@(posedge REF_CLK) disable iff (RST)
    done && buffered && !dre_q |=> tx_sr_q == $past(tx_buf_q))
    else $error("buffer not reloaded at byte end");
  chk_rxc_order: assert property (@(posedge REF_CLK) disable iff (RST)
    done && buffered |-> ##2 rxc_q)
    else $error("receive flag late");
  chk_txc_order: assert property (@(posedge REF_CLK) disable iff (RST)
    done && buffered && dre_q |-> ##1 !done_p2_q ##2 txc_q)
    else $error("transfer complete flag late");
  chk_deselect_abort: assert property (@(posedge REF_CLK) disable iff (RST)
    ss_n_s |=> bit_cnt_q == 3'h0 ##1 !MISO_OE)
    else $error("deselect did not abort");
  chk_irq_hold: assert property (@(posedge REF_CLK) disable iff (RST)
    buffered && rxc_q && irq_en_q[IE_RXC] && !wr_b && !wr_ie ##1 rxc_q |=> IRQ)
    else $error("request not held while flag set");
  chk_ovf_set: assert property (@(posedge REF_CLK) disable iff (RST)
    push && buffered && rx_cnt_q == RX_DEPTH && !pop |=> ovf_q)
    else $error("overflow flag not set");
  cov_buf_byte: cover property (@(posedge REF_CLK) disable iff (RST) done && buffered);
  cov_collision: cover property (@(posedge REF_CLK) disable iff (RST) $rose(write_collision_flag_q));
  cov_overflow: cover property (@(posedge REF_CLK) disable iff (RST) $rose(ovf_q));
  cov_abort: cover property (@(posedge REF_CLK) disable iff (RST) busy ##1 ss_n_s);

endmodule : scp_port
`default_nettype wire

// ===== verif/scp_host.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// Behavioural bus host driving the serial link
// ------------------------------------------------------------------
module scp_host (
  input wire logic go,
  input wire logic slow,
  input wire logic [1:0] mode,
  input wire logic lsb,
  input wire logic [7:0] tx,
  input wire logic [3:0] nbits,
  input wire logic miso,
  output logic sck,
  output logic ss_n,
  output logic mosi,
  output logic [7:0] rx,
  output logic busy
);
  int i;
  int idx;
  int half;
  // Link idles deselected with the clock parked
  initial begin
    sck = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
    rx = 8'h00;
    busy = 1'b0;
  end
  // One frame per go pulse; a short bit count aborts mid byte
  always @(posedge go) begin
    busy = 1'b1;
    half = slow ? 200 : 80;
    sck = mode[1];
    #43;
    ss_n = 1'b0;
    #(half);
    for (i = 0; i < nbits; i++) begin
      idx = lsb ? i : 7 - i;
      if (mode[0]) begin
        sck = ~sck;
        mosi = tx[idx];
        #(half);
        sck = ~sck;
        rx[idx] = miso;
        #(half);
      end else begin
        mosi = tx[idx];
        #(half);
        sck = ~sck;
        rx[idx] = miso;
        #(half);
        sck = ~sck;
      end
    end
    #(half);
    ss_n = 1'b1;
    mosi = ~mosi; // Released line must not keep showing the last bit
    #(half);
    busy = 1'b0;
  end
endmodule : scp_host
`default_nettype wire

// ===== verif/tb_spi_client_buffered_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_spi_client_buffered_port;
  import scp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd_s = 1'b0;
  logic dir = 1'b1;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic hlsb = 1'b0;
  logic pat = 1'b0;
  logic dp1 = 1'b1;
  logic evp = 1'b0;
  logic [1:0] hmode = 2'h0;
  logic [7:0] htx = 8'h00;
  logic [3:0] hn = 4'h8;
  logic [7:0] rdata, hrx, v, a, b, c;
  logic sck, ss_n, mosi, miso_o, miso_oe, irq, sck_ev, hbusy;
  wire logic miso_w;
  int bad_count = 0;
  int n_tests = 0;
  int run = 2;
  int rxq[$];
  // Undriven line toggles so a stale bit is never mistaken for data
  assign miso_w = miso_oe ? miso_o : pat;
  always #4 clk = ~clk;
  always @(posedge clk) pat <= ~pat;

  scp_port DUT (.REF_CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd_s), .REG_RDATA(rdata), .SCK(sck), .SS_N(ss_n), .MOSI(mosi),
    .MISO_DIR_OUT(dir), .MISO_O(miso_o), .MISO_OE(miso_oe), .IRQ(irq), .SCK_EVENT(sck_ev));
  scp_host HOST (.go(go), .slow(slow), .mode(hmode), .lsb(hlsb), .tx(htx), .nbits(hn),
    .miso(miso_w), .sck(sck), .ss_n(ss_n), .mosi(mosi), .rx(hrx), .busy(hbusy));

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task end_sim;
    $display("compares %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr_reg(input logic [2:0] ad, input logic [7:0] d);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task rd_reg(input logic [2:0] ad);
    @(posedge clk);
    addr <= ad;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg

  // Received bytes come back in arrival order
  task rd_data;
    rd_reg(ADDR_DATA);
    chk(v, 8'(rxq.pop_front()));
  endtask : rd_data

  // One host frame; the bound on the wait cuts a hang short
  task xfer(input logic [7:0] h, input logic [3:0] n);
    int k;
    @(posedge clk);
    htx <= h;
    hn <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    k = 0;
    while (hbusy && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (hbusy) begin
      bad_count++;
      end_sim();
    end
    if (n == 4'h8) rxq.push_back(int'(h));
  endtask : xfer

  // Buffered frame pair in one mode and bit order
  task buf_run(input logic [1:0] m, input logic o, input logic en);
    a = 8'($urandom);
    b = 8'($urandom);
    c = 8'($urandom);
    wr_reg(ADDR_CTRL_A, {1'b0, o, 5'h00, 1'b1});
    wr_reg(ADDR_CTRL_B, {2'h3, 4'h0, m});
    wr_reg(ADDR_IRQ_EN, {en, 7'h00});
    wr_reg(ADDR_FLAGS, 8'hFF);
    hmode <= m;
    hlsb <= o;
    wr_reg(ADDR_DATA, a);
    wr_reg(ADDR_DATA, b);
    wr_reg(ADDR_DATA, c);
    rd_reg(ADDR_FLAGS);
    chk(v & 8'hE1, 8'h00);
    xfer(8'($urandom), 4'h8);
    chk(hrx, a);
    rd_reg(ADDR_FLAGS);
    chk(v & 8'hE1, 8'hA0);
    chk({7'h00, irq}, {7'h00, en});
    rd_data();
    rd_reg(ADDR_FLAGS);
    chk(v & 8'hE1, 8'h20);
    xfer(8'($urandom), 4'h8);
    chk(hrx, b);
    rd_reg(ADDR_FLAGS);
    chk(v & 8'hE1, 8'hE0);
    rd_data();
    chk({7'h00, miso_oe}, 8'h00);
  endtask : buf_run

  // ----------------------------------------------------------------
  // Watchers: event level length and MISO direction
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    dp1 <= dir;
    evp <= sck_ev;
    run <= (sck_ev !== evp) ? 1 : run + 1;
    if (!rst && sck_ev !== evp && run < 2) chk(8'h01, 8'h02);
    if (miso_oe === 1'b1 && !dp1) chk(8'h01, 8'h00);
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(80395));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_reg(ADDR_CTRL_A);
    chk(v, CTRL_A_RST);
    rd_reg(ADDR_CTRL_B);
    chk(v, CTRL_B_RST);
    rd_reg(ADDR_IRQ_EN);
    chk(v, IRQ_EN_RST);
    rd_reg(ADDR_FLAGS);
    chk(v, 8'h00);
    wr_reg(ADDR_CTRL_A, 8'hFF);
    wr_reg(3'h7, 8'hFF);
    rd_reg(ADDR_CTRL_A);
    chk(v, CTRL_A_MASK);
    rd_reg(3'h7);
    chk(v, 8'h00);
    for (int i = 0; i < 8; i++) buf_run(2'(i), 1'(i >> 2), 1'(i));
    // Abort mid byte, then an overflow with the MISO pin as input
    wr_reg(ADDR_FLAGS, 8'hFF);
    dir <= 1'b0;
    slow <= 1'b1;
    xfer(8'h5A, 4'h4);
    rd_reg(ADDR_FLAGS);
    chk(v & 8'hC1, 8'h00);
    repeat (3) xfer(8'($urandom), 4'h8);
    rd_reg(ADDR_FLAGS);
    chk(v & 8'h81, 8'h81);
    rxq.delete(2);
    rd_data();
    rd_data();
    dir <= 1'b1;
    slow <= 1'b0;
    hmode <= 2'h0;
    // Normal mode: a write while busy is refused
    a = 8'($urandom);
    wr_reg(ADDR_CTRL_B, 8'h00);
    wr_reg(ADDR_IRQ_EN, 8'h01);
    wr_reg(ADDR_DATA, a);
    fork
      xfer(8'($urandom), 4'h8);
      begin
        repeat (80) @(posedge clk);
        wr_reg(ADDR_DATA, ~a);
      end
    join
    chk(hrx, a);
    rd_reg(ADDR_FLAGS);
    chk(v & 8'hC0, 8'hC0);
    chk({7'h00, irq}, 8'h01);
    rd_data();
    rd_reg(ADDR_FLAGS);
    chk(v & 8'hC0, 8'h00);
    chk({7'h00, irq}, 8'h00);
    end_sim();
  end
endmodule : tb_spi_client_buffered_port
`default_nettype wire
